// File: shared/tco_cfg.svh
// Register offsets, field codes and fixed counter values of the timer compare unit
`ifndef TCO_CFG_SVH
`define TCO_CFG_SVH

// ==========================================================================
// Register byte offsets
`define TCO_OFF_CTRL_A 12'h000
`define TCO_OFF_CTRL_B 12'h004
`define TCO_OFF_COUNT 12'h008
`define TCO_OFF_CMP_A 12'h00C
`define TCO_OFF_CMP_B 12'h010
`define TCO_OFF_FLAGS 12'h014
`define TCO_OFF_IRQ_EN 12'h018
`define TCO_OFF_PORT 12'h01C
`define TCO_OFF_DIR 12'h020

// ==========================================================================
// Counter extremes and reset values
`define TCO_BOTTOM 8'h00
`define TCO_MAX 8'hFF
`define TCO_RST_BYTE 8'h00
`define TCO_RST_PAIR 2'h0

// ==========================================================================
// Clock source select codes
`define TCO_CS_STOP 3'h0
`define TCO_CS_SYS 3'h1
`define TCO_CS_DIV8 3'h2
`define TCO_CS_DIV64 3'h3
`define TCO_CS_DIV256 3'h4
`define TCO_CS_DIV1024 3'h5
`define TCO_CS_EXT_FALL 3'h6
`define TCO_CS_EXT_RISE 3'h7

// Prescaler tap masks (low bits all ones marks the tap)
`define TCO_TAP8 10'h007
`define TCO_TAP64 10'h03F
`define TCO_TAP256 10'h0FF
`define TCO_TAP1024 10'h3FF

// ==========================================================================
// Compare output action codes
`define TCO_COM_NONE 2'h0
`define TCO_COM_TOGGLE 2'h1
`define TCO_COM_CLEAR 2'h2
`define TCO_COM_SET 2'h3

`endif

// File: shared/tco_pkg.sv
// Types shared by the timer compare unit
package tco_pkg;

    // ======================================================================
    // Waveform mode codes
    typedef enum logic [2:0] {
        TCO_WGM_NORMAL = 3'b000,
        TCO_WGM_PC_MAX = 3'b001,
        TCO_WGM_CTC = 3'b010,
        TCO_WGM_FAST_MAX = 3'b011,
        TCO_WGM_RSV4 = 3'b100,
        TCO_WGM_PC_CMPA = 3'b101,
        TCO_WGM_RSV6 = 3'b110,
        TCO_WGM_FAST_CMPA = 3'b111
    } tco_wgm_e;

    // ======================================================================
    // Register layouts
    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [1:0] rsvd;
        logic [1:0] wgm_lo;
    } tco_ctrl_a_s;

    typedef struct packed {
        logic force_a;
        logic force_b;
        logic [1:0] rsvd;
        logic wgm_hi;
        logic [2:0] cs;
    } tco_ctrl_b_s;

    typedef struct packed {
        logic [4:0] rsvd;
        logic flag_b;
        logic flag_a;
        logic ovf;
    } tco_flags_s;

endpackage

// File: rtl/tco_timer8.sv
// 8-bit timer/counter with two compare channels, waveform pins and APB registers
//
// Contract
// - Counter value zero is the floor; floor event drives waveform generator.
// - Counter value 255 is the fixed maximum.
// - Ceiling is 255 or compare_value_a, chosen by mode.
// - Clock source zero stops counter; otherwise each tick clears or counts.
// - Software reads and writes timer_count at any time.
// - Software write to timer_count beats a simultaneous count or clear.
// - Three-bit mode: low bits in control_a, high bit in control_b.
// - Equal count and compare value sets channel flag on next tick.
// - Set flag with enabled interrupt requests a compare interrupt.
// - Flag clears on interrupt service or software writing one.
// - Compare values double-buffered in PWM modes, direct otherwise.
// - Buffered compare value moves to active register only at ceiling.
// - Software compare access targets buffer when buffered, else active.
// - Force strobe in non-PWM modes acts like match, no flag, no clear.
// - Counter write blocks all matches in the next tick, even stopped.
// - Action code unbuffered; applies at next match or force strobe.
// - Action code zero leaves the compare output register unchanged.
// - Compare output registers clear to zero on reset.
// - Nonzero action code puts compare output on pin; direction stays separate.
// - Compare output registers keep values across mode changes.
// - Normal mode counts up, wraps 255 to zero, sets overflow then.
// - Clear-on-match mode clears counter when it equals compare_value_a.
// - Fast PWM ceiling 255 for mode 3, compare_value_a for mode 7.
// - Fast PWM action 2 clears on match, sets at floor; 3 inverts.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "tco_cfg.svh"

module tco_timer8
    import tco_pkg::*;
#(
    parameter int PRESCALE_W = 10
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // External count pin
    input wire logic count_pin_i,
    // Interrupt requests and service acknowledges
    output logic irq_overflow_o,
    output logic irq_compare_a_o,
    output logic irq_compare_b_o,
    input wire logic ack_overflow_i,
    input wire logic ack_compare_a_i,
    input wire logic ack_compare_b_i,
    // Waveform pins
    output logic compare_output_a_o,
    output logic compare_output_a_oe_o,
    output logic compare_output_b_o,
    output logic compare_output_b_oe_o
);

    // ======================================================================
    // Parameter check
    // Checked at elaboration; the tap masks assume ten bits
    if (PRESCALE_W != 10) begin : g_presc_check
        $error("PRESCALE_W must be 10 to provide the divide-by-1024 tap");
    end

    // ======================================================================
    // State
    tco_ctrl_a_s ctrl_a_reg;
    tco_ctrl_b_s ctrl_b_reg;
    tco_flags_s flags_reg;
    tco_flags_s flags_next;

    logic [2:0] irq_en_reg;
    logic [1:0] port_reg;
    logic [1:0] dir_reg;

    logic [7:0] count_reg;
    logic [7:0] count_next;

    logic [7:0] ocr_reg [2];
    logic [7:0] ocr_buf_reg [2];
    logic [1:0] oc_reg;
    logic [1:0] oc_next;

    logic block_reg;
    logic [PRESCALE_W-1:0] presc_reg;
    logic [2:0] pin_sync_reg;

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    logic [2:0] irq_reg;
    logic [1:0] pin_out_reg;
    logic [1:0] pin_oe_reg;

    // ======================================================================
    // APB decode
    // One wait state; read data is latched in the first access cycle
    wire logic acc_first = psel_i & penable_i & ~pready_reg;
    wire logic wr_take = psel_i & penable_i & pready_reg & pwrite_i;

    wire logic hit_ctrl_a = paddr_i == `TCO_OFF_CTRL_A;
    wire logic hit_ctrl_b = paddr_i == `TCO_OFF_CTRL_B;
    wire logic hit_count = paddr_i == `TCO_OFF_COUNT;
    wire logic hit_cmp_a = paddr_i == `TCO_OFF_CMP_A;
    wire logic hit_cmp_b = paddr_i == `TCO_OFF_CMP_B;
    wire logic hit_flags = paddr_i == `TCO_OFF_FLAGS;
    wire logic hit_irq_en = paddr_i == `TCO_OFF_IRQ_EN;
    wire logic hit_port = paddr_i == `TCO_OFF_PORT;
    wire logic hit_dir = paddr_i == `TCO_OFF_DIR;
    wire logic hit_any = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a | hit_cmp_b
                         | hit_flags | hit_irq_en | hit_port | hit_dir;

    wire logic [7:0] wbyte = pwdata_i[7:0];
    wire logic wr_count = wr_take & hit_count;
    wire logic [1:0] wr_cmp = {wr_take & hit_cmp_b, wr_take & hit_cmp_a};

    // ======================================================================
    // Mode decode
    wire tco_wgm_e mode = tco_wgm_e'({ctrl_b_reg.wgm_hi, ctrl_a_reg.wgm_lo});
    // Odd mode codes are the PWM family; phase-correct ones count up only here
    wire logic pwm_mode = mode[0];
    wire logic clears_at_top = (mode == TCO_WGM_CTC) | (mode == TCO_WGM_FAST_MAX)
                               | (mode == TCO_WGM_FAST_CMPA);

    wire logic top_is_cmpa = (mode == TCO_WGM_CTC) | (mode == TCO_WGM_FAST_CMPA);
    wire logic [7:0] top_val = top_is_cmpa ? ocr_reg[0] : `TCO_MAX;

    wire logic at_top = count_reg == top_val;
    wire logic at_max = count_reg == `TCO_MAX;

    // ======================================================================
    // Timer tick source
    wire logic ext_rise = pin_sync_reg[1] & ~pin_sync_reg[2];
    wire logic ext_fall = ~pin_sync_reg[1] & pin_sync_reg[2];

    logic tick;
    always_comb begin
        case (ctrl_b_reg.cs)
            `TCO_CS_STOP: tick = 1'b0;
            `TCO_CS_SYS: tick = 1'b1;
            `TCO_CS_DIV8: tick = (presc_reg & `TCO_TAP8) == `TCO_TAP8;
            `TCO_CS_DIV64: tick = (presc_reg & `TCO_TAP64) == `TCO_TAP64;
            `TCO_CS_DIV256: tick = (presc_reg & `TCO_TAP256) == `TCO_TAP256;
            `TCO_CS_DIV1024: tick = presc_reg == `TCO_TAP1024;
            `TCO_CS_EXT_FALL: tick = ext_fall;
            `TCO_CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // ======================================================================
    // Counter unit; always counts up (no dual-slope support)
    wire logic top_clear = tick & clears_at_top & at_top;
    wire logic bottom_evt = tick & pwm_mode & top_clear;
    wire logic ovf_set = tick & (pwm_mode ? top_clear : at_max);
    wire logic db_update = pwm_mode & tick & at_top;

    always_comb begin
        if (wr_count) begin
            count_next = wbyte;
        end else if (top_clear) begin
            count_next = `TCO_BOTTOM;
        end else if (tick) begin
            count_next = count_reg + 8'h01;
        end else begin
            count_next = count_reg;
        end
    end

    // ======================================================================
    // Compare channels (0 = A, 1 = B)
    wire logic [1:0] com [2];
    wire logic [1:0] force_req;
    wire logic [1:0] match_set;
    wire logic [7:0] ocr_next [2];
    wire logic [7:0] buf_next [2];
    assign com[0] = ctrl_a_reg.com_a;
    assign com[1] = ctrl_a_reg.com_b;

    assign force_req[0] = wr_take & hit_ctrl_b & wbyte[7] & ~pwm_mode;
    assign force_req[1] = wr_take & hit_ctrl_b & wbyte[6] & ~pwm_mode;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            // Blocking keeps a freshly loaded count from matching at once
            assign match_set[ch] = tick & (count_reg == ocr_reg[ch]) & ~block_reg;

            // Toggle in PWM only for channel A in modes 5 and 7 (wgm_hi set)
            wire logic pwm_toggle_ok = (ch == 0) & ctrl_b_reg.wgm_hi;
            assign buf_next[ch] = wr_cmp[ch] ? wbyte : ocr_buf_reg[ch];
            assign ocr_next[ch] = (wr_cmp[ch] & ~pwm_mode) ? wbyte :
                                  db_update ? ocr_buf_reg[ch] : ocr_reg[ch];

            always_comb begin
                oc_next[ch] = oc_reg[ch];
                if (pwm_mode) begin
                    if (match_set[ch]) begin
                        case (com[ch])
                            `TCO_COM_TOGGLE: oc_next[ch] = pwm_toggle_ok ? ~oc_reg[ch] : oc_reg[ch];
                            `TCO_COM_CLEAR: oc_next[ch] = 1'b0;
                            `TCO_COM_SET: oc_next[ch] = 1'b1;
                            default: oc_next[ch] = oc_reg[ch];
                        endcase
                    end
                    // Floor action wins so a compare value at the ceiling gives a steady level
                    if (bottom_evt) begin
                        case (com[ch])
                            `TCO_COM_CLEAR: oc_next[ch] = 1'b1;
                            `TCO_COM_SET: oc_next[ch] = 1'b0;
                            default: oc_next[ch] = oc_next[ch];
                        endcase
                    end
                end else if (match_set[ch] | force_req[ch]) begin
                    case (com[ch])
                        `TCO_COM_TOGGLE: oc_next[ch] = ~oc_reg[ch];
                        `TCO_COM_CLEAR: oc_next[ch] = 1'b0;
                        `TCO_COM_SET: oc_next[ch] = 1'b1;
                        default: oc_next[ch] = oc_reg[ch];
                    endcase
                end
            end
        end
    endgenerate

    // ======================================================================
    // Flags: hardware set wins over a clear in the same cycle
    wire tco_flags_s flag_set = '{rsvd: 5'h00, flag_b: match_set[1], flag_a: match_set[0], ovf: ovf_set};
    wire logic [2:0] w1c = (wr_take & hit_flags) ? wbyte[2:0] : 3'h0;
    wire logic [2:0] flag_clr = w1c | {ack_compare_b_i, ack_compare_a_i, ack_overflow_i};

    always_comb begin
        flags_next = flags_reg;
        flags_next.rsvd = 5'h00;
        flags_next[2:0] = (flags_reg[2:0] & ~flag_clr) | flag_set[2:0];
    end

    // ======================================================================
    // Read mux
    wire logic [7:0] cmp_rd_a = pwm_mode ? ocr_buf_reg[0] : ocr_reg[0];
    wire logic [7:0] cmp_rd_b = pwm_mode ? ocr_buf_reg[1] : ocr_reg[1];
    wire tco_ctrl_b_s ctrl_b_rd = '{force_a: 1'b0, force_b: 1'b0, rsvd: 2'h0,
                                     wgm_hi: ctrl_b_reg.wgm_hi, cs: ctrl_b_reg.cs};

    wire logic [7:0] rd_byte = hit_ctrl_a ? ctrl_a_reg :
                               hit_ctrl_b ? ctrl_b_rd :
                               hit_count ? count_reg :
                               hit_cmp_a ? cmp_rd_a :
                               hit_cmp_b ? cmp_rd_b :
                               hit_flags ? flags_reg :
                               hit_irq_en ? {5'h00, irq_en_reg} :
                               hit_port ? {6'h00, port_reg} :
                               hit_dir ? {6'h00, dir_reg} : 8'h00;

    // ======================================================================
    // Pin override
    wire logic [1:0] pin_next;
    assign pin_next[0] = (ctrl_a_reg.com_a != `TCO_COM_NONE) ? oc_reg[0] : port_reg[0];
    assign pin_next[1] = (ctrl_a_reg.com_b != `TCO_COM_NONE) ? oc_reg[1] : port_reg[1];

    // ======================================================================
    // Registers
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ctrl_a_reg <= '0;
            ctrl_b_reg <= '0;
            irq_en_reg <= 3'h0;
            port_reg <= `TCO_RST_PAIR;
            dir_reg <= `TCO_RST_PAIR;
        end else if (wr_take) begin
            if (hit_ctrl_a) begin
                ctrl_a_reg <= {wbyte[7:4], 2'h0, wbyte[1:0]};
            end
            if (hit_ctrl_b) begin
                ctrl_b_reg <= {4'h0, wbyte[3:0]};
            end
            if (hit_irq_en) begin
                irq_en_reg <= wbyte[2:0];
            end
            if (hit_port) begin
                port_reg <= wbyte[1:0];
            end
            if (hit_dir) begin
                dir_reg <= wbyte[1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            count_reg <= `TCO_RST_BYTE;
            block_reg <= 1'b0;
            flags_reg <= '0;
            oc_reg <= `TCO_RST_PAIR;
            for (int i = 0; i < 2; i++) begin
                ocr_reg[i] <= `TCO_RST_BYTE;
                ocr_buf_reg[i] <= `TCO_RST_BYTE;
            end
        end else begin
            count_reg <= count_next;
            block_reg <= wr_count | (block_reg & ~tick);
            flags_reg <= flags_next;
            oc_reg <= oc_next;
            for (int i = 0; i < 2; i++) begin
                ocr_reg[i] <= ocr_next[i];
                ocr_buf_reg[i] <= buf_next[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            presc_reg <= '0;
            pin_sync_reg <= 3'h0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
            pin_sync_reg <= {pin_sync_reg[1:0], count_pin_i};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc_first;
            pslverr_reg <= acc_first & ~hit_any;
            if (acc_first) begin
                prdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            irq_reg <= 3'h0;
            pin_out_reg <= `TCO_RST_PAIR;
            pin_oe_reg <= `TCO_RST_PAIR;
        end else begin
            irq_reg <= flags_reg[2:0] & irq_en_reg;
            pin_out_reg <= pin_next;
            pin_oe_reg <= dir_reg;
        end
    end

    // ======================================================================
    // Outputs
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;

    assign irq_overflow_o = irq_reg[0];
    assign irq_compare_a_o = irq_reg[1];
    assign irq_compare_b_o = irq_reg[2];

    assign compare_output_a_o = pin_out_reg[0];
    assign compare_output_b_o = pin_out_reg[1];
    assign compare_output_a_oe_o = pin_oe_reg[0];
    assign compare_output_b_oe_o = pin_oe_reg[1];

endmodule

// File: tb/tco_timer8_props.sv
// Port-level assertions for the timer compare unit
`timescale 1ns/1ps
`include "tco_cfg.svh"

module tco_timer8_props (
    // Clock, reset and bus
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Events and pins
    input wire logic irq_overflow_o,
    input wire logic irq_compare_a_o,
    input wire logic compare_output_a_o,
    input wire logic compare_output_a_oe_o,
    input wire logic compare_output_b_o
);
    // ========
    // Shadows from completed writes; refused writes never land
    logic [7:0] ctl_a_reg;
    logic [2:0] en_reg;
    logic [1:0] port_reg;
    logic [1:0] dir_reg;
    wire wr_done = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
    wire map_ok = (paddr_i <= `TCO_OFF_DIR) && (paddr_i[1:0] == 2'h0);

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            ctl_a_reg <= 8'h00;
            en_reg <= 3'h0;
            port_reg <= 2'h0;
            dir_reg <= 2'h0;
        end else if (wr_done) begin
            if (paddr_i == `TCO_OFF_CTRL_A) ctl_a_reg <= pwdata_i[7:0];
            if (paddr_i == `TCO_OFF_IRQ_EN) en_reg <= pwdata_i[2:0];
            if (paddr_i == `TCO_OFF_PORT) port_reg <= pwdata_i[1:0];
            if (paddr_i == `TCO_OFF_DIR) dir_reg <= pwdata_i[1:0];
        end
    end

    // ========
    // Properties
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence s_access; psel_i && penable_i && !pready_o; endsequence
    sequence s_done; psel_i && penable_i && pready_o; endsequence
    property p_ready_wait; s_access |=> s_done; endproperty
    property p_ready_pulse; pready_o |=> !pready_o; endproperty
    property p_err_map; s_access |=> (pslverr_o == !$past(map_ok)); endproperty
    property p_err_pair; pslverr_o |-> pready_o; endproperty
    property p_rdata_hi; pready_o |-> (prdata_o[31:8] == 24'h000000); endproperty
    property p_pass_a; (ctl_a_reg[7:6] == 2'h0) |=> (compare_output_a_o == $past(port_reg[0])); endproperty
    property p_pass_b; (ctl_a_reg[5:4] == 2'h0) |=> (compare_output_b_o == $past(port_reg[1])); endproperty
    property p_dir_a; 1'b1 |=> (compare_output_a_oe_o == $past(dir_reg[0])); endproperty
    property p_irq_a; irq_compare_a_o |-> $past(en_reg[1]); endproperty
    property p_irq_ovf; irq_overflow_o |-> $past(en_reg[0]); endproperty
    property p_rst_pins; $rose(nrst_i) |-> !compare_output_a_o && !compare_output_b_o; endproperty

    a_ready_wait: assert property (p_ready_wait) else $error("ready missing after wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_map: assert property (p_err_map) else $error("error flag disagrees with address");
    a_err_pair: assert property (p_err_pair) else $error("error without ready");
    a_rdata_hi: assert property (p_rdata_hi) else $error("upper read data not zero");
    a_pass_a: assert property (p_pass_a) else $error("pin a not port value");
    a_pass_b: assert property (p_pass_b) else $error("pin b not port value");
    a_dir_a: assert property (p_dir_a) else $error("pin a enable not direction");
    a_irq_a: assert property (p_irq_a) else $error("compare a request while masked");
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow request while masked");
    a_rst_pins: assert property (p_rst_pins) else $error("pins not low after reset");
endmodule

bind tco_timer8 tco_timer8_props u_props (
    .clk_sys_i,
    .nrst_i,
    .psel_i,
    .penable_i,
    .pwrite_i,
    .paddr_i,
    .pwdata_i,
    .prdata_o,
    .pready_o,
    .pslverr_o,
    .irq_overflow_o,
    .irq_compare_a_o,
    .compare_output_a_o,
    .compare_output_a_oe_o,
    .compare_output_b_o
);

// File: tb/tco_timer8_bench.sv
// Self-checking bench for the timer compare unit
`timescale 1ns/1ps
`include "tco_cfg.svh"

module tco_timer8_bench;
    // ========
    // Signals
    logic clk_sys_i = 1'b0;
    logic nrst_i, psel_i, penable_i, pwrite_i, ack_overflow_i, ack_compare_a_i, ack_compare_b_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, irq_overflow_o, irq_compare_a_o, irq_compare_b_o, er;
    logic compare_output_a_o, compare_output_a_oe_o, compare_output_b_o, compare_output_b_oe_o;
    logic [2:0] pc = 3'h0;
    wire count_pin_i = pc[2];
    int num_errors = 0;
    int check_count = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;
    // Slow external pin, well under the sampling limit
    always @(posedge clk_sys_i) pc <= pc + 3'h1;

    tco_timer8 dut (
        .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .count_pin_i,
        .irq_overflow_o, .irq_compare_a_o, .irq_compare_b_o,
        .ack_overflow_i, .ack_compare_a_i, .ack_compare_b_i,
        .compare_output_a_o, .compare_output_a_oe_o, .compare_output_b_o, .compare_output_b_oe_o
    );

    // ========
    // Shared tasks
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
            final_report();
        end
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // Idle edge so the next request never lands in this time step
        @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic wfor(ref logic s, input int lim);
        int k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(posedge clk_sys_i);
            k++;
        end
        chk("event_seen", 32'h1, 32'(k < lim));
        if (k >= lim) final_report();
    endtask

    task automatic run_brief();
        wr(`TCO_OFF_CTRL_B, 32'h1);
        cyc(2);
        wr(`TCO_OFF_CTRL_B, 32'h0);
    endtask

    // ========
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 9; i++) rchk("reset_val", 12'(i * 4), 32'h0);
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped_err", 32'h1, 32'(er));
        chk("unmapped_rd", 32'h0, rd);
    endtask

    task automatic t_clock();
        for (int c = 0; c < 8; c++) begin
            wr(`TCO_OFF_COUNT, 32'h0);
            wr(`TCO_OFF_CTRL_B, 32'(c));
            cyc(1100);
            wr(`TCO_OFF_CTRL_B, 32'h0);
            apb(1'b0, `TCO_OFF_COUNT, 32'h0);
            chk("count_moved", 32'(c != 0), 32'(rd != 0));
        end
    endtask

    task automatic t_ovf();
        wr(`TCO_OFF_CMP_A, 32'h80);
        wr(`TCO_OFF_IRQ_EN, 32'h7);
        wr(`TCO_OFF_COUNT, 32'hF0);
        wr(`TCO_OFF_FLAGS, 32'h7);
        wr(`TCO_OFF_CTRL_B, 32'h1);
        wfor(irq_overflow_o, 300);
        rchk("wrap_flags", `TCO_OFF_FLAGS, 32'h5);
        chk("irq_b", 32'h1, 32'(irq_compare_b_o));
        ack_overflow_i <= 1'b1;
        ack_compare_b_i <= 1'b1;
        @(posedge clk_sys_i);
        ack_overflow_i <= 1'b0;
        ack_compare_b_i <= 1'b0;
        rchk("ack_clear", `TCO_OFF_FLAGS, 32'h0);
        wfor(irq_compare_a_o, 300);
        wr(`TCO_OFF_FLAGS, 32'h2);
        apb(1'b0, `TCO_OFF_FLAGS, 32'h0);
        chk("w1c_a", 32'h0, 32'(rd[1]));
        wr(`TCO_OFF_CTRL_B, 32'h0);
    endtask

    task automatic t_block();
        wr(`TCO_OFF_CMP_A, 32'h20);
        for (int i = 0; i < 2; i++) begin
            wr(`TCO_OFF_FLAGS, 32'h7);
            wr(`TCO_OFF_COUNT, 32'h20 - 32'(i));
            run_brief();
            apb(1'b0, `TCO_OFF_FLAGS, 32'h0);
            chk("match_block", 32'(i), 32'(rd[1]));
        end
    endtask

    task automatic t_force();
        logic [7:0] ta [8] = '{8'h80, 8'hC0, 8'h40, 8'h40, 8'h00, 8'hC0, 8'hC3, 8'h83};
        logic [7:0] tb [8] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80};
        logic [7:0] te = 8'hFA;
        wr(`TCO_OFF_PORT, 32'h3);
        wr(`TCO_OFF_COUNT, 32'h33);
        wr(`TCO_OFF_FLAGS, 32'h7);
        for (int i = 0; i < 8; i++) begin
            wr(`TCO_OFF_CTRL_A, 32'(ta[i]));
            wr(`TCO_OFF_CTRL_B, 32'(tb[i]));
            cyc(2);
            chk("pin_a", 32'(te[i]), 32'(compare_output_a_o));
        end
        chk("pin_b", 32'h1, 32'(compare_output_b_o));
        wr(`TCO_OFF_DIR, 32'h3);
        rchk("force_flags", `TCO_OFF_FLAGS, 32'h0);
        rchk("force_count", `TCO_OFF_COUNT, 32'h33);
        chk("pin_a_oe", 32'h1, 32'(compare_output_a_oe_o));
        chk("pin_b_oe", 32'h1, 32'(compare_output_b_oe_o));
    endtask

    task automatic t_buffer();
        wr(`TCO_OFF_CTRL_A, 32'h0);
        wr(`TCO_OFF_CMP_B, 32'h10);
        wr(`TCO_OFF_CTRL_A, 32'h23);
        wr(`TCO_OFF_CMP_B, 32'h30);
        rchk("buf_read", `TCO_OFF_CMP_B, 32'h30);
        wr(`TCO_OFF_COUNT, 32'h0E);
        wr(`TCO_OFF_FLAGS, 32'h7);
        run_brief();
        rchk("old_active", `TCO_OFF_FLAGS, 32'h4);
        wr(`TCO_OFF_CTRL_B, 32'h1);
        wfor(irq_overflow_o, 400);
        wr(`TCO_OFF_CTRL_B, 32'h0);
        chk("pwm_floor", 32'h1, 32'(compare_output_b_o));
        wr(`TCO_OFF_COUNT, 32'h2E);
        wr(`TCO_OFF_FLAGS, 32'h7);
        run_brief();
        rchk("new_active", `TCO_OFF_FLAGS, 32'h4);
        chk("pwm_match", 32'h0, 32'(compare_output_b_o));
    endtask

    task automatic t_ctc();
        wr(`TCO_OFF_CTRL_A, 32'h2);
        wr(`TCO_OFF_CMP_A, 32'h08);
        wr(`TCO_OFF_COUNT, 32'h0);
        wr(`TCO_OFF_CTRL_B, 32'h1);
        repeat (6) begin
            apb(1'b0, `TCO_OFF_COUNT, 32'h0);
            chk("ctc_top", 32'h1, 32'(rd <= 32'h8));
        end
        wr(`TCO_OFF_CTRL_B, 32'h0);
    endtask

    // ========
    // Main sequence
    initial begin
        nrst_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        ack_overflow_i = 1'b0;
        ack_compare_a_i = 1'b0;
        ack_compare_b_i = 1'b0;
        cyc(6);
        nrst_i <= 1'b1;
        cyc(1);
        t_reset();
        t_clock();
        t_ovf();
        t_block();
        t_force();
        t_buffer();
        t_ctc();
        final_report();
    end
endmodule
